// ==== rtl/sweep_pkg.sv ====
// shared constants for the frequency sweep ramp control block
`default_nettype none
package sweep_pkg;
   localparam int DATA_W = 24;                      // register and value width
   localparam int ADDR_W = 5;                       // register address width
   localparam int CTRL_W = 8;                       // control register width
   // register addresses
   localparam logic [4:0] ADDR_SWEEP_CONTROL = 5'h14;
   localparam logic [4:0] ADDR_SWEEP_INCREMENT = 5'h15;
   localparam logic [4:0] ADDR_SWEEP_INCREMENT_COUNT = 5'h16;
   localparam logic [4:0] ADDR_SWEEP_HOLD_TIME = 5'h17;
   // control register bit positions
   localparam int BIT_CLEAR_FLAGS = 0;
   localparam int BIT_ENABLE = 1;
   localparam int BIT_TRIGGER = 2;
   localparam int BIT_REPEAT = 3;
   localparam int BIT_BEGIN_DOWNWARD = 4;
   localparam int BIT_EXT_TRIGGER = 5;
   localparam int BIT_SINGLE_STEP = 6;
   localparam int BIT_ONE_DIRECTION = 7;
   // reset values
   localparam logic [7:0] RST_SWEEP_CONTROL = 8'h00;
   localparam logic [23:0] RST_SWEEP_INCREMENT = 24'h000800;
   localparam logic [23:0] RST_SWEEP_INCREMENT_COUNT = 24'h000800;
   localparam logic [23:0] RST_SWEEP_HOLD_TIME = 24'h000800;
   localparam logic [23:0] ZERO_WORD = 24'h000000;
   localparam logic [23:0] ONE_WORD = 24'h000001;
   // accumulator operations
   typedef enum logic [1:0] {ACC_HOLD, ACC_LOAD, ACC_STEP} acc_op_t;
   // sweep sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_RAMP, ST_HOLD, ST_DWELL} sweep_state_t;
endpackage : sweep_pkg
`default_nettype wire

// ==== rtl/sweep_regs.sv ====
// register file of the sweep block with write-triggered ramp start pulse
`default_nettype none
module sweep_regs
   import sweep_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   output logic [DATA_W-1:0] rdata_reg,
   output logic [CTRL_W-1:0] ctrl_reg,
   output logic [DATA_W-1:0] step_reg,
   output logic [DATA_W-1:0] count_reg,
   output logic [DATA_W-1:0] dwell_reg,
   output logic sw_trig_reg
);
   logic ctrl_wr; // write hits the control register

   assign ctrl_wr = wr_en && (addr == ADDR_SWEEP_CONTROL);

   // register writes, one per address
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg <= RST_SWEEP_CONTROL;
         step_reg <= RST_SWEEP_INCREMENT;
         count_reg <= RST_SWEEP_INCREMENT_COUNT;
         dwell_reg <= RST_SWEEP_HOLD_TIME;
      end else if (wr_en) begin
         unique case (addr)
            ADDR_SWEEP_CONTROL: ctrl_reg <= wdata[CTRL_W-1:0];
            ADDR_SWEEP_INCREMENT: step_reg <= wdata;
            ADDR_SWEEP_INCREMENT_COUNT: count_reg <= wdata;
            ADDR_SWEEP_HOLD_TIME: dwell_reg <= wdata;
            default: ; // unmapped writes are dropped
         endcase
      end
   end

   // any control write with the trigger bit low fires a one-cycle trigger;
   // with the bit high the write is refused as a trigger
   always_ff @(posedge clk) begin
      if (rst) begin
         sw_trig_reg <= 1'b0;
      end else begin
         sw_trig_reg <= ctrl_wr && !wdata[BIT_TRIGGER]; // R3
      end
   end

   // registered read port, unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= ZERO_WORD;
      end else begin
         unique case (addr)
            ADDR_SWEEP_CONTROL: rdata_reg <= DATA_W'(ctrl_reg);
            ADDR_SWEEP_INCREMENT: rdata_reg <= step_reg;
            ADDR_SWEEP_INCREMENT_COUNT: rdata_reg <= count_reg;
            ADDR_SWEEP_HOLD_TIME: rdata_reg <= dwell_reg;
            default: rdata_reg <= ZERO_WORD;
         endcase
      end
   end
endmodule : sweep_regs
`default_nettype wire

// ==== rtl/sweep_accum.sv ====
// fractional value accumulator that steps up or down and reports wraps
`default_nettype none
module sweep_accum
   import sweep_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire acc_op_t op,
   input wire logic down,
   input wire logic [DATA_W-1:0] step,
   input wire logic [DATA_W-1:0] load_val,
   output logic [DATA_W-1:0] frac_reg,
   output logic wrap_up,
   output logic wrap_dn
);
   logic [DATA_W:0] sum_ext; // one extra bit catches carry or borrow

   // the extra bit of the 25-bit result is the wrap indication
   always_comb begin
      if (down) begin
         sum_ext = {1'b0, frac_reg} - {1'b0, step};
      end else begin
         sum_ext = {1'b0, frac_reg} + {1'b0, step};
      end
      wrap_up = (op == ACC_STEP) && !down && sum_ext[DATA_W];
      wrap_dn = (op == ACC_STEP) && down && sum_ext[DATA_W];
   end

   // value update; a wrap still stores the truncated result
   always_ff @(posedge clk) begin
      if (rst) begin
         frac_reg <= ZERO_WORD;
      end else begin
         unique case (op)
            ACC_HOLD: frac_reg <= frac_reg;
            ACC_LOAD: frac_reg <= load_val;
            ACC_STEP: frac_reg <= sum_ext[DATA_W-1:0]; // R10
         endcase
      end
   end
endmodule : sweep_accum
`default_nettype wire

// ==== rtl/sweep_ramp_ctrl.sv ====
// top of the frequency sweep ramp control: sequencer, flags, pin trigger
// Function
// R1 - clear bit asynchronously clears wrap flags
// R2 - sweep runs only while enabled, else reset
// R3 - control write triggers unless trigger bit set
// R4 - repeat bit retriggers ramps automatically
// R5 - without repeat each ramp needs a trigger
// R6 - start direction bit picks first ramp direction
// R7 - pin trigger accepted when external enable set
// R8 - single step: one step per trigger, hold
// R9 - one direction: hop to start at end
// R10 - step count and size registers, reset 800h
// R11 - repeat mode dwells at ramp ends
// R12 - software keeps span within allowed range
// R13 - software sets modulator to feed-forward order
// R14 - bidirectional repeat reverses after dwell
// R15 - wrap past limits sets overflow or underflow
`default_nettype none
module sweep_ramp_ctrl
   import sweep_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic REG_WR_EN,
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic [DATA_W-1:0] REG_WDATA,
   output logic [DATA_W-1:0] REG_RD_DATA,
   input wire logic GENERAL_OUTPUT_THREE,
   input wire logic [DATA_W-1:0] START_FRAC,
   output logic [DATA_W-1:0] SWEEP_FRAC,
   output logic RAMP_BUSY,
   output logic OVERFLOW_FLAG,
   output logic UNDERFLOW_FLAG
);
   logic [CTRL_W-1:0] ctrl_reg; // control register
   logic [DATA_W-1:0] step_reg; // step size
   logic [DATA_W-1:0] count_reg; // steps per ramp
   logic [DATA_W-1:0] dwell_reg; // dwell cycles
   logic sw_trig_reg; // write trigger pulse
   logic pin_reg; // previous pin level for edge detect
   logic trig; // combined trigger this cycle
   logic ramp_en, repeat_en, one_dir, single_step, ext_en, clr_flags;
   sweep_state_t state_reg, state_next; // sequencer state
   logic [DATA_W-1:0] left_reg, left_next; // steps left in ramp
   logic [DATA_W-1:0] dwell_left_reg, dwell_left_next; // dwell countdown
   logic dir_reg, dir_next; // 1 while ramping down
   acc_op_t acc_op; // accumulator request
   logic wrap_up, wrap_dn; // wrap indications from accumulator
   logic ramp_end; // ramp has no steps left
   logic fresh_reg; // no ramp taken since the sweep was enabled

   // decoded control bits
   assign ramp_en = ctrl_reg[BIT_ENABLE];
   assign repeat_en = ctrl_reg[BIT_REPEAT];
   assign one_dir = ctrl_reg[BIT_ONE_DIRECTION];
   assign single_step = ctrl_reg[BIT_SINGLE_STEP];
   assign ext_en = ctrl_reg[BIT_EXT_TRIGGER];
   assign clr_flags = ctrl_reg[BIT_CLEAR_FLAGS];
   assign ramp_end = (left_reg == ZERO_WORD);

   sweep_regs u_regs (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .wr_en(REG_WR_EN),
      .addr(REG_ADDR),
      .wdata(REG_WDATA),
      .rdata_reg(REG_RD_DATA),
      .ctrl_reg(ctrl_reg),
      .step_reg(step_reg),
      .count_reg(count_reg),
      .dwell_reg(dwell_reg),
      .sw_trig_reg(sw_trig_reg)
   );

   sweep_accum u_accum (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .op(acc_op),
      .down(dir_reg),
      .step(step_reg),
      .load_val(START_FRAC),
      .frac_reg(SWEEP_FRAC),
      .wrap_up(wrap_up),
      .wrap_dn(wrap_dn)
   );

   // pin history; the pin is already synchronous to the clock
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= GENERAL_OUTPUT_THREE;
      end
   end

   // a rising pin edge counts only while the pin trigger is enabled
   assign trig = sw_trig_reg ||
      (ext_en && GENERAL_OUTPUT_THREE && !pin_reg); // R7

   // sequencer next-state logic
   always_comb begin
      state_next = state_reg;
      left_next = left_reg;
      dwell_left_next = dwell_left_reg;
      dir_next = dir_reg;
      acc_op = ACC_HOLD;
      if (!ramp_en) begin
         // disabled: held in reset, value parked on the start frequency
         state_next = ST_IDLE; // R2
         left_next = ZERO_WORD;
         dwell_left_next = ZERO_WORD;
         dir_next = ctrl_reg[BIT_BEGIN_DOWNWARD]; // R6
         acc_op = ACC_LOAD;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               // every ramp out of idle waits for a trigger
               if (trig) begin
                  state_next = ST_RAMP; // R3 R5
                  left_next = count_reg; // R10
                  // the enabling write and the start bit land together,
                  // so the first direction is taken here as well as while off
                  if (fresh_reg) begin
                     dir_next = ctrl_reg[BIT_BEGIN_DOWNWARD]; // R6
                  end
               end
            end
            ST_RAMP: begin
               if (!ramp_end) begin
                  acc_op = ACC_STEP; // R10
                  left_next = left_reg - ONE_WORD;
                  if (single_step) begin
                     state_next = ST_HOLD; // R8
                  end
               end else begin
                  if (one_dir) begin
                     acc_op = ACC_LOAD; // R9
                  end else begin
                     dir_next = !dir_reg; // R14
                  end
                  if (repeat_en) begin
                     state_next = ST_DWELL; // R11
                     dwell_left_next = dwell_reg;
                  end else begin
                     state_next = ST_IDLE; // R5
                  end
               end
            end
            ST_HOLD: begin
               // frequency held until the next trigger
               if (trig) begin
                  state_next = ST_RAMP; // R8
               end
            end
            ST_DWELL: begin
               if (dwell_left_reg <= ONE_WORD) begin
                  state_next = ST_RAMP; // R4
                  left_next = count_reg;
               end else begin
                  dwell_left_next = dwell_left_reg - ONE_WORD; // R11
               end
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         state_reg <= ST_IDLE;
         left_reg <= ZERO_WORD;
         dwell_left_reg <= ZERO_WORD;
         dir_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         left_reg <= left_next;
         dwell_left_reg <= dwell_left_next;
         dir_reg <= dir_next;
      end
   end

   // busy flag follows the next state so it stays a plain flop
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         RAMP_BUSY <= 1'b0;
      end else begin
         RAMP_BUSY <= (state_next != ST_IDLE);
      end
   end

   // first-ramp marker: set while disabled, dropped once a ramp is taken;
   // later ramps keep the direction left at the last ramp end instead
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         fresh_reg <= 1'b1;
      end else if (!ramp_en) begin
         fresh_reg <= 1'b1; // R2
      end else if (state_reg == ST_IDLE && trig) begin
         fresh_reg <= 1'b0; // R6
      end
   end

   // wrap flags: the clear bit acts without the clock and wins while high,
   // so a wrap in that window is lost by design
   always_ff @(posedge CLK_SYS or posedge clr_flags) begin
      if (clr_flags) begin
         OVERFLOW_FLAG <= 1'b0; // R1
         UNDERFLOW_FLAG <= 1'b0; // R1
      end else if (SYS_RST) begin
         OVERFLOW_FLAG <= 1'b0;
         UNDERFLOW_FLAG <= 1'b0;
      end else begin
         OVERFLOW_FLAG <= OVERFLOW_FLAG || wrap_up; // R15
         UNDERFLOW_FLAG <= UNDERFLOW_FLAG || wrap_dn; // R15
      end
   end

   // checks kept beside the logic they guard
   a_clear_flags: assert property ( // R1
      @(posedge CLK_SYS) disable iff (SYS_RST)
      clr_flags |-> !OVERFLOW_FLAG && !UNDERFLOW_FLAG)
      else $error("wrap flag set while clear bit high");

   a_disable_idle: assert property ( // R2
      @(posedge CLK_SYS) disable iff (SYS_RST)
      !ramp_en |=> !RAMP_BUSY && SWEEP_FRAC == $past(START_FRAC))
      else $error("sweep active while disabled");

   a_trig_refused: assert property ( // R3
      @(posedge CLK_SYS) disable iff (SYS_RST)
      state_reg == ST_IDLE && ramp_en && REG_WR_EN && !ext_en &&
      REG_ADDR == ADDR_SWEEP_CONTROL && REG_WDATA[BIT_TRIGGER] &&
      !sw_trig_reg ##1 ramp_en |-> state_reg == ST_IDLE)
      else $error("ramp started on write with trigger bit set");

   a_write_starts: assert property ( // R3
      @(posedge CLK_SYS) disable iff (SYS_RST)
      state_reg == ST_IDLE && ramp_en && sw_trig_reg
      |=> state_reg == ST_RAMP && left_reg == $past(count_reg))
      else $error("control write did not start a ramp");

   a_repeat_retrig: assert property ( // R4
      @(posedge CLK_SYS) disable iff (SYS_RST)
      ramp_en && state_reg == ST_DWELL && dwell_left_reg <= ONE_WORD
      |=> state_reg == ST_RAMP)
      else $error("repeat mode failed to retrigger");

   a_no_repeat_idle: assert property ( // R5
      @(posedge CLK_SYS) disable iff (SYS_RST)
      ramp_en && state_reg == ST_RAMP && ramp_end && !repeat_en
      |=> state_reg == ST_IDLE)
      else $error("ramp continued without repeat or trigger");

   // the direction taken by the first ramp after enabling
   a_first_dir: assert property ( // R6
      @(posedge CLK_SYS) disable iff (SYS_RST)
      ramp_en && state_reg == ST_IDLE && trig && fresh_reg
      |=> dir_reg == $past(ctrl_reg[BIT_BEGIN_DOWNWARD]))
      else $error("first ramp direction wrong");

   // while disabled the direction follows the start bit
   a_off_dir: assert property ( // R6
      @(posedge CLK_SYS) disable iff (SYS_RST)
      !ramp_en |=> dir_reg == $past(ctrl_reg[BIT_BEGIN_DOWNWARD]))
      else $error("direction not parked while disabled");

   a_pin_trigger: assert property ( // R7
      @(posedge CLK_SYS) disable iff (SYS_RST)
      state_reg == ST_IDLE && ramp_en && ext_en && $rose(GENERAL_OUTPUT_THREE)
      |=> RAMP_BUSY)
      else $error("pin trigger ignored");

   a_single_hold: assert property ( // R8
      @(posedge CLK_SYS) disable iff (SYS_RST)
      ramp_en && state_reg == ST_HOLD && !trig
      |=> $stable(SWEEP_FRAC))
      else $error("frequency moved while holding a single step");

   a_one_dir_hop: assert property ( // R9
      @(posedge CLK_SYS) disable iff (SYS_RST)
      ramp_en && state_reg == ST_RAMP && ramp_end && one_dir
      |=> SWEEP_FRAC == $past(START_FRAC) && dir_reg == $past(dir_reg))
      else $error("one-direction ramp did not hop to start");

   a_step_size: assert property ( // R10
      @(posedge CLK_SYS) disable iff (SYS_RST)
      ramp_en && state_reg == ST_RAMP && !ramp_end |=> SWEEP_FRAC ==
      ($past(dir_reg) ? $past(SWEEP_FRAC) - $past(step_reg)
                      : $past(SWEEP_FRAC) + $past(step_reg)))
      else $error("step applied with wrong size");

   a_dwell_load: assert property ( // R11
      @(posedge CLK_SYS) disable iff (SYS_RST)
      ramp_en && state_reg == ST_RAMP && ramp_end && repeat_en
      |=> state_reg == ST_DWELL && dwell_left_reg == $past(dwell_reg))
      else $error("dwell not started at ramp end");

   // the frequency must not move while dwelling at a ramp end
   a_dwell_hold: assert property ( // R11
      @(posedge CLK_SYS) disable iff (SYS_RST)
      ramp_en && state_reg == ST_DWELL |=> $stable(SWEEP_FRAC))
      else $error("frequency moved during dwell");

   a_reverse_dir: assert property ( // R14
      @(posedge CLK_SYS) disable iff (SYS_RST)
      ramp_en && state_reg == ST_RAMP && ramp_end && !one_dir
      |=> dir_reg != $past(dir_reg))
      else $error("bidirectional ramp did not reverse");

   a_wrap_flag: assert property ( // R15
      @(posedge CLK_SYS) disable iff (SYS_RST)
      wrap_up && !clr_flags ##1 !clr_flags |-> OVERFLOW_FLAG)
      else $error("overflow not flagged");

   a_under_flag: assert property ( // R15
      @(posedge CLK_SYS) disable iff (SYS_RST)
      wrap_dn && !clr_flags ##1 !clr_flags |-> UNDERFLOW_FLAG)
      else $error("underflow not flagged");
endmodule : sweep_ramp_ctrl
`default_nettype wire

// ==== test/sweep_host.sv ====
// host model that drives the register port and the trigger pin
`default_nettype none
module sweep_host
   import sweep_pkg::*;
(
   input wire logic clk,
   output logic wr_en,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] wdata,
   input wire logic [DATA_W-1:0] rd_data,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus at time zero
   initial begin
      wr_en = 1'b0;
      addr = 5'h00;
      wdata = 24'h000000;
      pin = 1'b0;
   end
   // one write; callers keep count times step small so the span stays legal
   // the modulator order lives outside this block, so nothing is set here
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr_en = 1'b0;
      // released data never keeps the last value
      wdata = ~d;
   endtask : wr
   // read shows one edge after the address is sampled
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(negedge clk);
      addr = a;
      repeat (2) @(negedge clk);
      d = rd_data;
   endtask : rd
   // one-cycle rising pulse on the trigger pin
   task automatic pulse;
      @(negedge clk);
      pin = 1'b1;
      @(negedge clk);
      pin = 1'b0;
   endtask : pulse
endmodule : sweep_host
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the sweep ramp control block
`default_nettype none
module tb
   import sweep_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [23:0] S = 24'h100000;
   logic clk_sys, sys_rst, wr_en, pin, busy, ovf, unf;
   logic [4:0] addr;
   logic [23:0] wdata, rd_data, start, frac, prev, stp, d;
   int bad_count, cmp_count, ups, dns;
   sweep_ramp_ctrl uut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
      .REG_WR_EN(wr_en), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_RD_DATA(rd_data), .GENERAL_OUTPUT_THREE(pin),
      .START_FRAC(start), .SWEEP_FRAC(frac), .RAMP_BUSY(busy),
      .OVERFLOW_FLAG(ovf), .UNDERFLOW_FLAG(unf));
   sweep_host host (.clk(clk_sys), .wr_en(wr_en), .addr(addr),
      .wdata(wdata), .rd_data(rd_data), .pin(pin));
   // clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // counts steps up and down seen on the swept value
   always @(posedge clk_sys) begin
      if (frac - prev === stp) ups++;
      if (prev - frac === stp) dns++;
      prev <= frac;
   end
   task automatic chk(input string n, input logic [23:0] s,
         input logic [23:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   // bounded wait for the busy level
   task automatic wait_b(input logic l);
      int i;
      i = 0;
      while (busy !== l && i < 60) begin
         @(negedge clk_sys);
         i++;
      end
      chk("busy", {23'h0, busy}, {23'h0, l});
   endtask : wait_b
   task automatic clr;
      @(negedge clk_sys);
      ups = 0;
      dns = 0;
   endtask : clr
   task automatic ctl(input logic [23:0] v);
      host.wr(ADDR_SWEEP_CONTROL, v);
   endtask : ctl
   task automatic stop_test;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic t_regs;
      host.rd(ADDR_SWEEP_CONTROL, d);
      chk("ctrl", d, 24'h000000);
      host.rd(ADDR_SWEEP_INCREMENT, d);
      chk("step", d, 24'h000800);
      host.rd(ADDR_SWEEP_INCREMENT_COUNT, d);
      chk("count", d, 24'h000800);
      host.rd(ADDR_SWEEP_HOLD_TIME, d);
      chk("dwell", d, 24'h000800);
      host.rd(5'h1f, d);
      chk("unmapped", d, 24'h000000);
      host.wr(ADDR_SWEEP_INCREMENT, stp);
      host.wr(ADDR_SWEEP_INCREMENT_COUNT, 24'h000004);
      host.rd(ADDR_SWEEP_INCREMENT, d);
      chk("step rw", d, stp);
   endtask : t_regs
   // disabled: value tracks the start and nothing runs
   task automatic t_off;
      ctl(24'h000004);
      start = S + 24'h1;
      repeat (3) @(negedge clk_sys);
      chk("frac off", frac, S + 24'h1);
      chk("busy off", {23'h0, busy}, 24'h0);
      start = S;
   endtask : t_off
   task automatic t_trig;
      ctl(24'h000006);
      repeat (10) @(negedge clk_sys);
      chk("busy trig1", {23'h0, busy}, 24'h0);
      clr();
      ctl(24'h000002);
      wait_b(1'b1);
      wait_b(1'b0);
      chk("ups", 24'(ups), 24'd4);
      chk("dns", 24'(dns), 24'd0);
      repeat (10) @(negedge clk_sys);
      chk("no retrig", {23'h0, busy}, 24'h0);
   endtask : t_trig
   task automatic t_down;
      ctl(24'h000000);
      clr();
      ctl(24'h000012);
      wait_b(1'b1);
      wait_b(1'b0);
      chk("dn dns", 24'(dns), 24'd4);
      chk("dn ups", 24'(ups), 24'd0);
   endtask : t_down
   // two steps, end cycle, three dwell cycles: about 16 steps in 48
   task automatic t_rep;
      ctl(24'h000000);
      host.wr(ADDR_SWEEP_INCREMENT_COUNT, 24'h000002);
      host.wr(ADDR_SWEEP_HOLD_TIME, 24'h000003);
      clr();
      ctl(24'h00000a);
      repeat (48) @(negedge clk_sys);
      chk("rep busy", {23'h0, busy}, 24'h1);
      chk("dwell", 24'(ups + dns >= 14 && ups + dns <= 18), 24'h1);
      chk("reverse", 24'(ups - dns <= 2 && dns - ups <= 2), 24'h1);
      ctl(24'h000000);
   endtask : t_rep
   task automatic t_one;
      host.wr(ADDR_SWEEP_INCREMENT_COUNT, 24'h000003);
      clr();
      ctl(24'h000082);
      wait_b(1'b1);
      wait_b(1'b0);
      chk("one ups", 24'(ups), 24'd3);
      chk("one dns", 24'(dns), 24'd0);
      chk("hop", frac, S);
   endtask : t_one
   task automatic t_single;
      ctl(24'h000000);
      clr();
      ctl(24'h000042);
      repeat (8) @(negedge clk_sys);
      chk("ss1", frac, S + stp);
      chk("ss ups", 24'(ups), 24'd1);
      ctl(24'h000042);
      repeat (8) @(negedge clk_sys);
      chk("ss2", frac, S + 24'h20);
   endtask : t_single
   task automatic t_pin;
      ctl(24'h000000);
      ctl(24'h000006);
      host.pulse();
      repeat (6) @(negedge clk_sys);
      chk("pin off", {23'h0, busy}, 24'h0);
      ctl(24'h000026);
      clr();
      host.pulse();
      wait_b(1'b1);
      wait_b(1'b0);
      chk("pin ups", 24'(ups), 24'd3);
   endtask : t_pin
   task automatic t_flag;
      ctl(24'h000000);
      start = 24'hffffe0;
      ctl(24'h000002);
      wait_b(1'b1);
      wait_b(1'b0);
      chk("ovf", {23'h0, ovf}, 24'h1);
      chk("unf0", {23'h0, unf}, 24'h0);
      ctl(24'h000003);
      chk("ovf clr", {23'h0, ovf}, 24'h0);
      ctl(24'h000000);
      start = 24'h000010;
      ctl(24'h000012);
      wait_b(1'b1);
      wait_b(1'b0);
      chk("unf", {23'h0, unf}, 24'h1);
      ctl(24'h000001);
      chk("unf clr", {23'h0, unf}, 24'h0);
   endtask : t_flag
   // main sequence
   initial begin
      sys_rst = 1'b1;
      start = S;
      stp = 24'h000010;
      prev = 24'h000000;
      bad_count = 0;
      cmp_count = 0;
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_regs();
      t_off();
      t_trig();
      t_down();
      t_rep();
      t_one();
      t_single();
      t_pin();
      t_flag();
      stop_test();
   end
   // watchdog well past the expected run length
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule : tb
`default_nettype wire
